/* File: src/asrs_sequencer.sv */
`timescale 1ns/100ps
// Functional notes
// - Setup start drives chip select, output enable low, byte enables, address valid.
// - Variant A: first read of a run has setup of at least two cycles.
// - Variant B: every setup period lasts at least one cycle, no extra.
// - Strobe period drives read strobe low for programmed strobe cycles.
// - Hold period returns strobe high, keeps address and byte enables stable.
// - Read data captured on the edge ending the strobe period.
// - Output enable released after hold unless another read follows next.
// - Variant A: chip select stays low seven minus hold cycles after hold.
// - Variant B: chip select released exactly at end of hold.
// - Counts are in this block's clock cycles, the chosen timing unit.
// - Setup or strobe field of zero counts as one cycle.
// - Field values are direct cycle counts, not counts minus one.
// - Hold of zero gives a hold period of zero cycles.
module asrs_sequencer
  import asrs_pkg::*;
#(
  parameter int VARIANT = ASRS_VAR_A
) (
  input wire logic clk_in,                          // 100 MHz clock, timing unit
  input wire logic rst_n_in,                        // Async reset, active low
  input wire logic req_valid_in,                    // Read request pending
  input wire asrs_req_t req_in,                     // Address and byte enables
  input wire asrs_timing_t timing_in,               // Setup, strobe, hold counts
  input wire logic [ASRS_DATA_W-1:0] ext_data_in,   // Data bus from SRAM
  output logic req_ready_out,                       // Request was taken in the previous cycle
  output logic rd_valid_out,                        // Read data valid pulse
  output logic [ASRS_DATA_W-1:0] rd_data_out,       // Captured read data
  output logic chip_select_n_out,                   // Chip select, active low
  output logic output_enable_n_out,                 // Output enable, active low
  output logic read_strobe_n_out,                   // Internal read strobe
  output logic [ASRS_BE_W-1:0] byte_lane_enable_n_out, // Byte enables, active low
  output logic [ASRS_ADDR_W-1:0] ext_address_out,   // Address
  output logic busy_out                             // Sequencer not idle
);
  if (VARIANT != ASRS_VAR_A && VARIANT != ASRS_VAR_B) begin : g_bad_variant
    $error("asrs: bad VARIANT");
  end

  localparam bit IS_A = (VARIANT == ASRS_VAR_A);

  asrs_state_t state_q, state_d;
  logic [ASRS_DATA_W-1:0] ext_data_s1_q, ext_data_s2_q;
  logic cap1_q, cap2_q;
  logic first_q;
  asrs_timing_t tim_q;

  wire logic [ASRS_CNT_W-1:0] setup_eff = (timing_in.setup == '0) ? ASRS_SETUP_MIN
                                          : timing_in.setup;
  wire logic [ASRS_CNT_W-1:0] setup_first = (IS_A && setup_eff < ASRS_SETUP_MIN_FIRST_A)
                                          ? ASRS_SETUP_MIN_FIRST_A : setup_eff;
  wire logic [ASRS_CNT_W-1:0] strobe_eff = (tim_q.strobe == '0) ? ASRS_CNT_ONE
                                           : tim_q.strobe;
  wire logic [ASRS_CNT_W-1:0] hold_cnt = {{(ASRS_CNT_W-ASRS_HOLD_W){1'b0}}, tim_q.hold};
  wire logic [ASRS_CNT_W-1:0] tail_cnt = ASRS_CS_TAIL_BASE_A - hold_cnt;
  wire logic hold_zero = (tim_q.hold == '0);
  wire logic tail_zero = !IS_A || (tail_cnt == '0);

  logic phase_last;
  logic load;
  logic [ASRS_CNT_W-1:0] load_val;

  wire logic in_idle = (state_q == ASRS_IDLE);
  wire logic run_end = (state_q == ASRS_HOLD && phase_last)
                       || (state_q == ASRS_STROBE && phase_last && hold_zero);
  wire logic take = req_valid_in && (in_idle || run_end || state_q == ASRS_TAIL);
  wire logic first_sel = in_idle || (state_q == ASRS_TAIL);

  always_comb begin
    state_d = state_q;
    load = 1'b0;
    load_val = ASRS_CNT_ONE;
    unique case (state_q)
      ASRS_IDLE, ASRS_TAIL: begin
        if (take) begin
          state_d = ASRS_SETUP;
          load = 1'b1;
          load_val = IS_A ? setup_first : setup_eff;
        end else if (state_q == ASRS_TAIL && phase_last) begin
          state_d = ASRS_IDLE;
        end
      end
      ASRS_SETUP: begin
        if (phase_last) begin
          state_d = ASRS_STROBE;
          load = 1'b1;
          load_val = strobe_eff;
        end
      end
      ASRS_STROBE, ASRS_HOLD: begin
        if (state_q == ASRS_STROBE && phase_last && !hold_zero) begin
          state_d = ASRS_HOLD;
          load = 1'b1;
          load_val = hold_cnt;
        end else if (run_end && take) begin
          state_d = ASRS_SETUP;
          load = 1'b1;
          load_val = setup_eff;
        end else if (run_end) begin
          state_d = tail_zero ? ASRS_IDLE : ASRS_TAIL;
          load = 1'b1;
          load_val = tail_cnt;
        end
      end
      default: state_d = ASRS_IDLE;
    endcase
  end

  asrs_counter #(.WIDTH(ASRS_CNT_W)) u_cnt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(load),
    .value_in(load_val),
    .last_out(phase_last)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ASRS_IDLE;
      tim_q <= '0;
      first_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) tim_q <= timing_in;
      if (take) first_q <= first_sel;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_data_s1_q <= '0;
      ext_data_s2_q <= '0;
      cap1_q <= 1'b0;
      cap2_q <= 1'b0;
    end else begin
      // First stage samples at the edge ending the strobe; later stages only delay
      ext_data_s1_q <= ext_data_in;
      ext_data_s2_q <= ext_data_s1_q;
      cap1_q <= (state_q == ASRS_STROBE) && phase_last;
      cap2_q <= cap1_q;
    end
  end

  // Bus pins registered from the next state so they change at phase edges
  wire logic act_d = (state_d != ASRS_IDLE);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chip_select_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      byte_lane_enable_n_out <= '1;
      ext_address_out <= '0;
      req_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
      busy_out <= 1'b0;
    end else begin
      chip_select_n_out <= !act_d;
      output_enable_n_out <= !(state_d inside {ASRS_SETUP, ASRS_STROBE, ASRS_HOLD});
      read_strobe_n_out <= (state_d != ASRS_STROBE);
      if (take) begin
        byte_lane_enable_n_out <= ~req_in.byte_en;
        ext_address_out <= req_in.addr;
      end
      req_ready_out <= take;
      rd_valid_out <= cap2_q;
      if (cap2_q) rd_data_out <= ext_data_s2_q;
      busy_out <= act_d;
    end
  end

  // Cycle counts of the strobe and of the chip-select tail, seen from the pins
  logic [ASRS_CNT_W-1:0] stb_run_q, tail_run_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stb_run_q <= '0;
      tail_run_q <= '0;
    end else begin
      stb_run_q <= read_strobe_n_out ? '0 : ASRS_CNT_W'(stb_run_q + 1'b1);
      tail_run_q <= (!chip_select_n_out && output_enable_n_out)
                    ? ASRS_CNT_W'(tail_run_q + 1'b1) : '0;
    end
  end

  strobe_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(read_strobe_n_out) |-> stb_run_q == $past(strobe_eff))
    else $error("strobe length differs from programmed count");
  setup_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (IS_A && first_q && $fell(read_strobe_n_out)) |-> $past(!output_enable_n_out, 2))
    else $error("first setup under two cycles");
  cs_oe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !output_enable_n_out |-> !chip_select_n_out)
    else $error("output enable without chip select");
  strobe_in_oe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !read_strobe_n_out |-> !output_enable_n_out && !chip_select_n_out)
    else $error("strobe outside cycle");
  hold_stable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($rose(read_strobe_n_out) && !req_ready_out)
      |-> $stable(ext_address_out) && $stable(byte_lane_enable_n_out))
    else $error("address or byte enables changed at hold start");
  capture_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_valid_out |-> $past(!read_strobe_n_out, 3) && $past(read_strobe_n_out, 2))
    else $error("capture not at strobe end");
  tail_b_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!IS_A && $rose(output_enable_n_out)) |-> chip_select_n_out)
    else $error("chip select held on variant B");
  tail_a_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (IS_A && $rose(output_enable_n_out) && tail_cnt != '0) |-> !chip_select_n_out)
    else $error("chip select released early on variant A");
  tail_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (IS_A && $rose(chip_select_n_out) && $past(output_enable_n_out))
      |-> tail_run_q == $past(tail_cnt))
    else $error("chip select tail length wrong on variant A");
  addr_stable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!read_strobe_n_out && !req_ready_out) |-> $stable(ext_address_out))
    else $error("address changed in strobe");

  read_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) rd_valid_out);
  b2b_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_valid_out ##[1:20] rd_valid_out);
  tail_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(chip_select_n_out));
  hold_zero_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(read_strobe_n_out) && output_enable_n_out);
endmodule : asrs_sequencer

/* File: src/asrs_pkg.sv */
package asrs_pkg;
  localparam int ASRS_ADDR_W = 20;
  localparam int ASRS_DATA_W = 32;
  localparam int ASRS_BE_W = 4;
  localparam int ASRS_CNT_W = 6;
  localparam int ASRS_HOLD_W = 3;
  localparam int ASRS_VAR_A = 0;
  localparam int ASRS_VAR_B = 1;
  localparam logic [ASRS_CNT_W-1:0] ASRS_SETUP_MIN_FIRST_A = 6'h02;
  localparam logic [ASRS_CNT_W-1:0] ASRS_SETUP_MIN = 6'h01;
  localparam logic [ASRS_CNT_W-1:0] ASRS_CS_TAIL_BASE_A = 6'h07;
  localparam logic [ASRS_CNT_W-1:0] ASRS_CNT_ONE = 6'h01;

  typedef struct packed {
    logic [ASRS_ADDR_W-1:0] addr;
    logic [ASRS_BE_W-1:0] byte_en;
  } asrs_req_t;

  typedef struct packed {
    logic [ASRS_CNT_W-1:0] setup;
    logic [ASRS_CNT_W-1:0] strobe;
    logic [ASRS_HOLD_W-1:0] hold;
  } asrs_timing_t;

  typedef enum logic [2:0] {
    ASRS_IDLE = 3'b000,
    ASRS_SETUP = 3'b001,
    ASRS_STROBE = 3'b011,
    ASRS_HOLD = 3'b010,
    ASRS_TAIL = 3'b110
  } asrs_state_t;
endpackage : asrs_pkg

/* File: src/asrs_counter.sv */
`timescale 1ns/100ps
// Down counter for one phase; load value is the phase length in cycles
module asrs_counter
  import asrs_pkg::*;
#(
  parameter int WIDTH = ASRS_CNT_W
) (
  input wire logic clk_in,                // Clock
  input wire logic rst_n_in,              // Async reset, active low
  input wire logic load_in,               // Load a new phase length
  input wire logic [WIDTH-1:0] value_in,  // Phase length
  output logic last_out                   // Current cycle ends the phase
);
  logic [WIDTH-1:0] cnt_q;
  wire logic [WIDTH-1:0] cnt_d;

  if (WIDTH < 3) begin : g_bad_width
    $error("asrs_counter: WIDTH too small");
  end

  assign cnt_d = load_in ? value_in : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
  assign last_out = (cnt_q == WIDTH'(ASRS_CNT_ONE));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule : asrs_counter

/* File: verif/asrs_sram_model.sv */
`timescale 1ns/100ps
// Static RAM read side: a word only while selected and enabled, junk otherwise
module asrs_sram_model
  import asrs_pkg::*;
#(
  parameter int ACC_NS = 3  // Access time, within setup plus strobe
) (
  input wire logic clk_in,                        // Clock, paces the junk pattern only
  input wire logic chip_select_n_in,              // Chip select, active low
  input wire logic output_enable_n_in,            // Output enable, active low
  input wire logic [ASRS_ADDR_W-1:0] address_in,  // Address
  output logic [ASRS_DATA_W-1:0] data_out         // Data towards the sequencer
);
  logic [ASRS_DATA_W-1:0] junk_q;
  logic [ASRS_DATA_W-1:0] word;
  initial junk_q = 32'h5a5a3c3c;
  always @(posedge clk_in) junk_q <= ~junk_q;
  assign word = {~address_in[15:0], address_in[15:0]};
  // Released bus changes every cycle so a late sample cannot match
  assign #(ACC_NS) data_out = (!chip_select_n_in && !output_enable_n_in) ? word : junk_q;
endmodule : asrs_sram_model

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
  import asrs_pkg::*;
  logic clk_in;
  logic rst_n_in = 1'b0;
  logic req_valid = 1'b0;
  logic sel = 1'b0;
  asrs_req_t req = '0;
  asrs_timing_t tm = '0;
  logic [1:0] rdy, rvl, csn, oen, stn, bsy;
  logic [ASRS_DATA_W-1:0] dat [2];
  logic [ASRS_DATA_W-1:0] rdd [2];
  logic [ASRS_BE_W-1:0] ben [2];
  logic [ASRS_ADDR_W-1:0] adr [2];
  logic [ASRS_ADDR_W-1:0] q [$];
  int error_cnt = 0;
  int n_compared = 0;
  int c_su, c_sb, c_ho, c_tl, c_rd, su, st, h;
  logic seen;
  int rows [5][3] = '{'{1, 2, 1}, '{0, 0, 0}, '{3, 1, 7}, '{2, 4, 3}, '{5, 3, 2}};

  for (genvar i = 0; i < 2; i++) begin : g_v
    asrs_sequencer #(.VARIANT(i)) u_dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid && (sel == 1'(i))),
      .req_in(req), .timing_in(tm), .ext_data_in(dat[i]), .req_ready_out(rdy[i]),
      .rd_valid_out(rvl[i]), .rd_data_out(rdd[i]), .chip_select_n_out(csn[i]),
      .output_enable_n_out(oen[i]), .read_strobe_n_out(stn[i]),
      .byte_lane_enable_n_out(ben[i]), .ext_address_out(adr[i]), .busy_out(bsy[i]));
    asrs_sram_model u_mem (.clk_in(clk_in), .chip_select_n_in(csn[i]),
      .output_enable_n_in(oen[i]), .address_in(adr[i]), .data_out(dat[i]));
  end

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, sv, ev);
    end
  endtask : chk

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Phase lengths as seen on the pins of the selected instance
  always @(posedge clk_in) begin
    if (rst_n_in) begin
      if (!csn[sel] && !oen[sel] && stn[sel] && !seen) c_su++;
      if (!stn[sel]) c_sb++;
      if (!stn[sel]) seen = 1'b1;
      if (!oen[sel] && stn[sel] && seen) c_ho++;
      if (!csn[sel] && oen[sel]) c_tl++;
      if (rvl[sel] && q.size() > 0) begin
        c_rd++;
        chk(rdd[sel], {~q[0][15:0], q[0][15:0]});
        void'(q.pop_front());
      end
    end
  end

  task automatic rd(input logic [19:0] a, input logic [3:0] be);
    int k;
    req_valid = 1'b1;
    req = '{addr: a, byte_en: be};
    q.push_back(a);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (rdy[sel] !== 1'b1 && k < 60);
    chk(rdy[sel], 1);
    chk({adr[sel], ben[sel], csn[sel], oen[sel]}, {a, ~be, 2'b00});
  endtask : rd

  task automatic fin(input int esu, esb, eho, etl, erd);
    int k;
    req_valid = 1'b0;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (bsy[sel] !== 1'b0 && k < 200);
    // Read data arrives a few cycles after the strobe, possibly after idle
    repeat (4) @(negedge clk_in);
    chk(c_su, esu);
    chk(c_sb, esb);
    chk(c_ho, eho);
    chk(c_tl, etl);
    chk(c_rd, erd);
    $display("test done variant %0d timing %0d/%0d/%0d", sel, tm.setup, tm.strobe, tm.hold);
    {c_su, c_sb, c_ho, c_tl, c_rd, seen} = '0;
  endtask : fin

  initial begin
    {c_su, c_sb, c_ho, c_tl, c_rd, seen} = '0;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int v = 0; v < 2; v++) begin
      sel = v[0];
      for (int r = 0; r < 5; r++) begin
        tm = '{setup: 6'(rows[r][0]), strobe: 6'(rows[r][1]), hold: 3'(rows[r][2])};
        rd(20'(r * 4099 + v * 77), 4'(r + 5));
        su = (rows[r][0] == 0) ? 1 : rows[r][0];
        if (v == 0 && su < 2) su = 2;
        st = (rows[r][1] == 0) ? 1 : rows[r][1];
        h = rows[r][2];
        fin(su, st, h, (v == 0) ? 7 - h : 0, 1);
      end
      // Back-to-back run: later setup is one cycle, enable stays low between
      tm = '{setup: 6'h01, strobe: 6'h01, hold: 3'h1};
      rd(20'h0abcd, 4'h3);
      rd(20'h54321, 4'hc);
      fin((v == 0) ? 2 : 1, 2, 3, (v == 0) ? 6 : 0, 2);
    end
    // Reset in mid-read forces the idle pin levels at once
    tm = '{setup: 6'h04, strobe: 6'h04, hold: 3'h2};
    rd(20'h00fff, 4'hf);
    req_valid = 1'b0;
    rst_n_in = 1'b0;
    #1;
    chk({csn[sel], oen[sel], stn[sel], bsy[sel], adr[sel]}, {4'he, 20'h0});
    q.delete();
    @(negedge clk_in);
    rst_n_in = 1'b1;
    {c_su, c_sb, c_ho, c_tl, c_rd, seen} = '0;
    tm = '{setup: 6'h01, strobe: 6'h02, hold: 3'h1};
    rd(20'h12345, 4'h1);
    fin(1, 2, 1, 0, 1);
    final_report();
  end

  initial begin
    #300000;
    error_cnt++;
    final_report();
  end
endmodule : tb
